// file: rtl/uee_pkg.sv
// shared constants and types for the evaluation endpoint application block
package uee_pkg;

    // =========================================================
    // clock and timing
    localparam int UEE_CLK_MHZ = 100;
    localparam int UEE_BLINK_HALF_MS = 50;
    localparam int UEE_BLINK_HALF_CYC = UEE_BLINK_HALF_MS * 1000 * UEE_CLK_MHZ;

    // =========================================================
    // packet sizes
    localparam int UEE_GEN_MAX_PKT = 16;
    localparam int UEE_MAIN_MAX_PKT = 64;
    localparam int UEE_MAIN_BUF_BYTES = 128;
    localparam int UEE_KEY_PKT_BYTES = 2;

    // =========================================================
    // field layouts and codes
    localparam int UEE_LED_W = 2;
    localparam int UEE_LED_LSB = 0;
    localparam logic [7:0] UEE_KEY_REPORT_ID = 8'h01;
    localparam logic [1:0] UEE_CODE_IDLE = 2'h0;
    localparam logic [1:0] UEE_CODE_LOOP = 2'h1;
    localparam logic [1:0] UEE_CODE_PRINT = 2'h2;
    localparam logic [1:0] UEE_CODE_SCAN = 2'h3;

    // =========================================================
    // reset values
    localparam logic [UEE_LED_W-1:0] UEE_LED_RST = 2'h0;
    localparam logic [7:0] UEE_SCAN_SEED = 8'h00;

    // =========================================================
    // types
    typedef enum logic [3:0] {
        UEE_IDLE = 4'b0001,
        UEE_LOOP = 4'b0010,
        UEE_PRINT = 4'b0100,
        UEE_SCAN = 4'b1000
    } uee_mode_t;

    typedef struct packed {
        logic [7:0] data;
        logic last;
    } uee_beat_t;

endpackage

// file: rtl/uee_app.sv
// endpoint application logic: key reports, LED pipe, test modes, link LED
//
// Summary of operation
// RQ1 - key press or release sends interrupt IN report
// RQ2 - generic OUT pipe accepts host bulk packets
// RQ3 - generic OUT packet first byte lights LEDs
// RQ4 - generic pipes carry at most 16 bytes
// RQ5 - main pipes 64-byte packets, 128-byte double buffer
// RQ6 - main pipes are bulk, carry three modes
// RQ7 - scan mode keeps supplying main IN data
// RQ8 - print mode keeps accepting main OUT data
// RQ9 - loop-back echoes main OUT packets on IN
// RQ10 - host command selects mode, no manual setting
// RQ11 - link LED steady after enumeration completes
// RQ12 - link LED blinks while data moves
// RQ13 - suspend indicator falls when leaving suspend
// RQ14 - wake circuit pulses on indicator falling edge
// RQ15 - echo exact and ordered, stall when full
`timescale 1ns/1ps

module uee_app #(
    parameter int BLINK_HALF_CYC = uee_pkg::UEE_BLINK_HALF_CYC
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic test_key,
    input wire logic configured,
    input wire logic bus_suspended,
    input wire logic mode_cmd_valid,
    input wire logic [1:0] mode_cmd,
    output uee_pkg::uee_mode_t test_mode,
    output logic ep1_in_valid,
    output uee_pkg::uee_beat_t ep1_in_beat,
    input wire logic ep1_in_ready,
    input wire logic ep1_out_valid,
    input wire uee_pkg::uee_beat_t ep1_out_beat,
    output logic ep1_out_ready,
    input wire logic ep2_out_valid,
    input wire uee_pkg::uee_beat_t ep2_out_beat,
    output logic ep2_out_ready,
    output logic ep2_in_valid,
    output uee_pkg::uee_beat_t ep2_in_beat,
    input wire logic ep2_in_ready,
    output logic [uee_pkg::UEE_LED_W-1:0] led_pipe,
    output logic link_status_led,
    output logic suspend_indicator
);

    localparam logic [6:0] MAIN_MAX = 7'(uee_pkg::UEE_MAIN_MAX_PKT);
    localparam logic [4:0] GEN_MAX = 5'(uee_pkg::UEE_GEN_MAX_PKT);
    localparam logic [5:0] SCAN_LAST = 6'(uee_pkg::UEE_MAIN_MAX_PKT - 1);
    localparam logic [31:0] BLINK_LOAD = 32'(BLINK_HALF_CYC - 1);

    function automatic uee_pkg::uee_mode_t decode_mode(input logic [1:0] c);
        case (c)
            uee_pkg::UEE_CODE_LOOP: decode_mode = uee_pkg::UEE_LOOP;
            uee_pkg::UEE_CODE_PRINT: decode_mode = uee_pkg::UEE_PRINT;
            uee_pkg::UEE_CODE_SCAN: decode_mode = uee_pkg::UEE_SCAN;
            default: decode_mode = uee_pkg::UEE_IDLE;
        endcase
    endfunction

    // =========================================================
    // mode selection
    uee_pkg::uee_mode_t mode_r;
    logic mode_chg;

    // any accepted command restarts main pipe state, even the same mode
    assign mode_chg = mode_cmd_valid;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            mode_r <= uee_pkg::UEE_IDLE;
        end else if (mode_cmd_valid) begin
            mode_r <= decode_mode(mode_cmd); // see RQ10
        end
    end

    assign test_mode = mode_r;

    // =========================================================
    // key report on interrupt IN pipe
    logic key_prev_r;
    logic key_pend_r;
    logic key_snap_r;
    logic ep1_in_valid_r;
    uee_pkg::uee_beat_t ep1_in_beat_r;
    logic key_change;
    logic key_start;

    assign key_change = test_key != key_prev_r;
    assign key_start = !ep1_in_valid_r && key_pend_r;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            key_prev_r <= 1'b0;
        end else begin
            key_prev_r <= test_key;
        end
    end

    // a change in the start cycle keeps the request pending
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            key_pend_r <= 1'b0;
        end else if (key_change) begin
            key_pend_r <= 1'b1; // see RQ1
        end else if (key_start) begin
            key_pend_r <= 1'b0;
        end
    end

    // report: id byte then key state byte
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ep1_in_valid_r <= 1'b0;
            ep1_in_beat_r <= '0;
            key_snap_r <= 1'b0;
        end else if (key_start) begin
            ep1_in_valid_r <= 1'b1; // see RQ1
            ep1_in_beat_r.data <= uee_pkg::UEE_KEY_REPORT_ID;
            ep1_in_beat_r.last <= 1'b0;
            key_snap_r <= key_prev_r;
        end else if (ep1_in_valid_r && ep1_in_ready) begin
            if (ep1_in_beat_r.last) begin
                ep1_in_valid_r <= 1'b0;
            end else begin
                ep1_in_beat_r.data <= {7'h00, key_snap_r};
                ep1_in_beat_r.last <= 1'b1;
            end
        end
    end

    assign ep1_in_valid = ep1_in_valid_r;
    assign ep1_in_beat = ep1_in_beat_r;

    // =========================================================
    // LED control on generic OUT pipe
    logic [4:0] gen_cnt_r;
    logic [uee_pkg::UEE_LED_W-1:0] led_r;
    logic ep1_out_fire;

    assign ep1_out_ready = 1'b1; // see RQ2
    assign ep1_out_fire = ep1_out_valid && ep1_out_ready;

    // bytes past the packet limit are taken and dropped, never stall
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            gen_cnt_r <= 5'h00;
        end else if (ep1_out_fire) begin
            if (ep1_out_beat.last) begin
                gen_cnt_r <= 5'h00;
            end else if (gen_cnt_r != GEN_MAX) begin
                gen_cnt_r <= gen_cnt_r + 5'h01; // see RQ4
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            led_r <= uee_pkg::UEE_LED_RST;
        end else if (ep1_out_fire && gen_cnt_r == 5'h00) begin
            led_r <= ep1_out_beat.data[uee_pkg::UEE_LED_LSB +:
                                       uee_pkg::UEE_LED_W]; // see RQ3
        end
    end

    assign led_pipe = led_r;

    // =========================================================
    // main pipes: loop-back buffer of two packet slots
    logic [7:0] mem [0:uee_pkg::UEE_MAIN_BUF_BYTES-1];
    logic [1:0] slot_full_r;
    logic [6:0] slot_len_r [0:1];
    logic wr_slot_r;
    logic rd_slot_r;
    logic [6:0] wr_cnt_r;
    logic [5:0] rd_cnt_r;
    logic ep2_out_fire;
    logic in_load;
    logic loop_take;
    logic loop_done;
    logic [6:0] wr_len;

    always_comb begin
        case (mode_r)
            uee_pkg::UEE_LOOP: ep2_out_ready = !slot_full_r[wr_slot_r];
            uee_pkg::UEE_PRINT: ep2_out_ready = 1'b1; // see RQ8
            default: ep2_out_ready = 1'b0;
        endcase
    end

    assign ep2_out_fire = ep2_out_valid && ep2_out_ready;
    assign wr_len = (wr_cnt_r == MAIN_MAX) ? MAIN_MAX : wr_cnt_r + 7'h01;
    assign in_load = !ep2_in_valid || ep2_in_ready;
    assign loop_take = mode_r == uee_pkg::UEE_LOOP && !mode_chg &&
                       in_load && slot_full_r[rd_slot_r];
    assign loop_done = loop_take &&
                       {1'b0, rd_cnt_r} + 7'h01 == slot_len_r[rd_slot_r];

    // print mode data is sunk here with no storage
    always_ff @(posedge sys_clk) begin
        if (ep2_out_fire && mode_r == uee_pkg::UEE_LOOP &&
            wr_cnt_r != MAIN_MAX) begin
            mem[{wr_slot_r, wr_cnt_r[5:0]}] <= ep2_out_beat.data; // see RQ9
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst || mode_chg) begin
            wr_cnt_r <= 7'h00;
            wr_slot_r <= 1'b0;
            slot_len_r[0] <= 7'h00;
            slot_len_r[1] <= 7'h00;
        end else if (ep2_out_fire && mode_r == uee_pkg::UEE_LOOP) begin
            if (ep2_out_beat.last) begin
                slot_len_r[wr_slot_r] <= wr_len; // see RQ15
                wr_slot_r <= !wr_slot_r;
                wr_cnt_r <= 7'h00;
            end else if (wr_cnt_r != MAIN_MAX) begin
                wr_cnt_r <= wr_cnt_r + 7'h01; // see RQ5
            end
        end
    end

    // fill and drain always touch different slots
    always_ff @(posedge sys_clk) begin
        if (rst || mode_chg) begin
            slot_full_r <= 2'h0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (ep2_out_fire && ep2_out_beat.last &&
                    mode_r == uee_pkg::UEE_LOOP && wr_slot_r == i[0]) begin
                    slot_full_r[i] <= 1'b1;
                end else if (loop_done && rd_slot_r == i[0]) begin
                    slot_full_r[i] <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst || mode_chg) begin
            rd_cnt_r <= 6'h00;
            rd_slot_r <= 1'b0;
        end else if (loop_done) begin
            rd_cnt_r <= 6'h00;
            rd_slot_r <= !rd_slot_r; // see RQ15
        end else if (loop_take) begin
            rd_cnt_r <= rd_cnt_r + 6'h01;
        end
    end

    // =========================================================
    // main IN register: echo or scan pattern
    logic ep2_in_valid_r;
    uee_pkg::uee_beat_t ep2_in_beat_r;
    logic [5:0] scan_cnt_r;
    logic scan_take;

    assign scan_take = mode_r == uee_pkg::UEE_SCAN && !mode_chg && in_load;

    always_ff @(posedge sys_clk) begin
        if (rst || mode_chg) begin
            scan_cnt_r <= 6'h00;
        end else if (scan_take) begin
            scan_cnt_r <= (scan_cnt_r == SCAN_LAST) ? 6'h00 :
                          scan_cnt_r + 6'h01;
        end
    end

    // a mode command drops any half-sent IN packet
    always_ff @(posedge sys_clk) begin
        if (rst || mode_chg) begin
            ep2_in_valid_r <= 1'b0;
            ep2_in_beat_r <= '0;
        end else if (loop_take) begin
            ep2_in_valid_r <= 1'b1; // see RQ9
            ep2_in_beat_r.data <= mem[{rd_slot_r, rd_cnt_r}];
            ep2_in_beat_r.last <= loop_done;
        end else if (scan_take) begin
            ep2_in_valid_r <= 1'b1; // see RQ7
            ep2_in_beat_r.data <= uee_pkg::UEE_SCAN_SEED + {2'h0, scan_cnt_r};
            ep2_in_beat_r.last <= scan_cnt_r == SCAN_LAST;
        end else if (ep2_in_ready) begin
            ep2_in_valid_r <= 1'b0; // see RQ6
        end
    end

    assign ep2_in_valid = ep2_in_valid_r;
    assign ep2_in_beat = ep2_in_beat_r;

    // =========================================================
    // link LED and suspend indicator
    logic [31:0] act_cnt_r;
    logic [31:0] blink_cnt_r;
    logic blink_ph_r;
    logic link_r;
    logic susp_r;
    logic activity;

    assign activity = (ep1_in_valid_r && ep1_in_ready) || ep1_out_fire ||
                      ep2_out_fire || (ep2_in_valid_r && ep2_in_ready);

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            act_cnt_r <= 32'h0;
        end else if (activity) begin
            act_cnt_r <= BLINK_LOAD + BLINK_LOAD + 32'h1;
        end else if (act_cnt_r != 32'h0) begin
            act_cnt_r <= act_cnt_r - 32'h1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            blink_cnt_r <= 32'h0;
            blink_ph_r <= 1'b0;
        end else if (blink_cnt_r == BLINK_LOAD) begin
            blink_cnt_r <= 32'h0;
            blink_ph_r <= !blink_ph_r; // see RQ12
        end else begin
            blink_cnt_r <= blink_cnt_r + 32'h1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            link_r <= 1'b0;
        end else begin
            link_r <= configured &&
                      (act_cnt_r == 32'h0 || blink_ph_r); // see RQ11
        end
    end

    // external wake pulse keys off the falling edge of this output
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            susp_r <= 1'b0;
        end else begin
            susp_r <= bus_suspended; // see RQ13
        end
    end

    assign link_status_led = link_r;
    assign suspend_indicator = susp_r;

    // =========================================================
    // assertions
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    a_key_pend_set: assert property (key_change |=> key_pend_r) // see RQ1
        else $error("key change did not raise a report request");
    a_key_two_byte: assert property (
        ep1_in_valid && ep1_in_ready && !ep1_in_beat.last
        |=> ep1_in_valid && ep1_in_beat.last) // see RQ1
        else $error("key report not two bytes");
    a_led_decode: assert property (ep1_out_fire && gen_cnt_r == 5'h00
        |=> led_pipe == $past(ep1_out_beat.data[1:0])) // see RQ3
        else $error("LED not taken from first byte");
    a_gen_limit: assert property (gen_cnt_r <= GEN_MAX) // see RQ4
        else $error("generic byte count beyond limit");
    a_main_limit: assert property (wr_cnt_r <= MAIN_MAX) // see RQ5
        else $error("main byte count beyond limit");
    a_mode_select: assert property (mode_cmd_valid
        |=> test_mode == decode_mode($past(mode_cmd))) // see RQ10
        else $error("mode command not applied");
    a_scan_supply: assert property (
        test_mode == uee_pkg::UEE_SCAN && !mode_cmd_valid
        |=> ep2_in_valid) // see RQ7
        else $error("scan mode left IN pipe empty");
    a_print_accept: assert property (
        test_mode == uee_pkg::UEE_PRINT |-> ep2_out_ready) // see RQ8
        else $error("print mode refused OUT data");
    a_loop_stall: assert property (test_mode == uee_pkg::UEE_LOOP &&
        slot_full_r == 2'h3 |-> !ep2_out_ready) // see RQ15
        else $error("OUT taken with both slots full");
    a_in_hold: assert property (ep2_in_valid && !ep2_in_ready &&
        !mode_cmd_valid |=> ep2_in_valid && $stable(ep2_in_beat)) // see RQ6
        else $error("IN beat changed while stalled");
    a_link_steady: assert property (configured && act_cnt_r == 32'h0
        |=> link_status_led) // see RQ11
        else $error("link LED not steady when idle");
    a_suspend_fall: assert property ($fell(bus_suspended)
        |=> $fell(suspend_indicator)) // see RQ13
        else $error("suspend indicator did not fall");

    c_loop_echo: cover property (test_mode == uee_pkg::UEE_LOOP &&
        ep2_in_valid && ep2_in_ready && ep2_in_beat.last);
    c_scan_pkt: cover property (test_mode == uee_pkg::UEE_SCAN &&
        ep2_in_valid && ep2_in_ready && ep2_in_beat.last);
    c_key_report: cover property (ep1_in_valid && ep1_in_ready &&
        ep1_in_beat.last);
    c_both_full: cover property (slot_full_r == 2'h3);

endmodule

// file: bench/uee_host_model.sv
// host-side model: sends OUT packets, takes IN beats
`timescale 1ns/1ps

module uee_host_model (
    input wire logic sys_clk,
    input wire logic slow,
    input wire logic ep1_in_valid,
    input wire uee_pkg::uee_beat_t ep1_in_beat,
    output logic ep1_in_ready,
    output logic ep1_out_valid,
    output uee_pkg::uee_beat_t ep1_out_beat,
    input wire logic ep1_out_ready,
    output logic ep2_out_valid,
    output uee_pkg::uee_beat_t ep2_out_beat,
    input wire logic ep2_out_ready,
    input wire logic ep2_in_valid,
    input wire uee_pkg::uee_beat_t ep2_in_beat,
    output logic ep2_in_ready
);
    uee_pkg::uee_beat_t rx1[$];
    uee_pkg::uee_beat_t rx2[$];

    initial begin
        ep1_in_ready = 1'b0;
        ep2_in_ready = 1'b0;
        ep1_out_valid = 1'b0;
        ep2_out_valid = 1'b0;
        ep1_out_beat = '0;
        ep2_out_beat = '0;
    end

    // ========
    // sink side: a slow host takes one beat every other cycle
    always @(posedge sys_clk) begin
        ep1_in_ready <= slow ? ~ep1_in_ready : 1'b1;
        ep2_in_ready <= slow ? ~ep2_in_ready : 1'b1;
        if (ep1_in_valid && ep1_in_ready)
            rx1.push_back(ep1_in_beat);
        if (ep2_in_valid && ep2_in_ready)
            rx2.push_back(ep2_in_beat);
    end

    // ========
    // source side: beats held until taken; released data is inverted
    task automatic send_pkt(input bit main, input int n,
            input logic [7:0] b0);
        uee_pkg::uee_beat_t bt;
        for (int i = 0; i < n; i++) begin
            bt.data = b0 + 8'(i);
            bt.last = (i == n - 1);
            if (main) begin
                ep2_out_valid <= 1'b1;
                ep2_out_beat <= bt;
            end else begin
                ep1_out_valid <= 1'b1;
                ep1_out_beat <= bt;
            end
            do @(posedge sys_clk);
            while (!(main ? ep2_out_ready : ep1_out_ready));
        end
        bt.data = ~bt.data;
        bt.last = 1'b0;
        ep1_out_valid <= 1'b0;
        ep2_out_valid <= 1'b0;
        if (main)
            ep2_out_beat <= bt;
        else
            ep1_out_beat <= bt;
        @(posedge sys_clk);
    endtask
endmodule

// file: bench/uee_app_test.sv
// self-checking bench for the endpoint application block
`timescale 1ns/1ps

module uee_app_test;
    localparam int BH = 8;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic test_key = 1'b0;
    logic configured = 1'b0;
    logic bus_suspended = 1'b0;
    logic mode_cmd_valid = 1'b0;
    logic [1:0] mode_cmd = 2'h0;
    logic slow = 1'b0;
    uee_pkg::uee_mode_t test_mode;
    logic ep1_in_valid, ep1_in_ready, ep1_out_valid, ep1_out_ready;
    logic ep2_in_valid, ep2_in_ready, ep2_out_valid, ep2_out_ready;
    uee_pkg::uee_beat_t ep1_in_beat, ep1_out_beat;
    uee_pkg::uee_beat_t ep2_in_beat, ep2_out_beat;
    logic [uee_pkg::UEE_LED_W-1:0] led_pipe;
    logic link_status_led;
    logic suspend_indicator;
    logic [1:0] saw;
    logic [8:0] key_exp [4] = '{9'h002, 9'h003, 9'h002, 9'h001};
    int err_total = 0;
    int samples_checked = 0;
    int cyc = 0;

    always #5 sys_clk = ~sys_clk;

    uee_app #(.BLINK_HALF_CYC(BH)) u_dut (.sys_clk, .rst, .test_key,
        .configured, .bus_suspended, .mode_cmd_valid, .mode_cmd,
        .test_mode, .ep1_in_valid, .ep1_in_beat, .ep1_in_ready,
        .ep1_out_valid, .ep1_out_beat, .ep1_out_ready, .ep2_out_valid,
        .ep2_out_beat, .ep2_out_ready, .ep2_in_valid, .ep2_in_beat,
        .ep2_in_ready, .led_pipe, .link_status_led, .suspend_indicator);

    uee_host_model u_host (.sys_clk, .slow, .ep1_in_valid, .ep1_in_beat,
        .ep1_in_ready, .ep1_out_valid, .ep1_out_beat, .ep1_out_ready,
        .ep2_out_valid, .ep2_out_beat, .ep2_out_ready, .ep2_in_valid,
        .ep2_in_beat, .ep2_in_ready);

    // ========
    // wake circuit: one clock-wide pulse per falling edge of the indicator
    logic susp_seen_r = 1'b0;
    logic wake_pulse = 1'b0;
    int wake_count = 0;

    always @(posedge sys_clk) begin
        susp_seen_r <= suspend_indicator;
        wake_pulse <= susp_seen_r && !suspend_indicator;
        if (wake_pulse)
            wake_count++;
    end

    // ========
    // shared helpers
    task automatic complete_run();
        if (err_total == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [15:0] exp,
            input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            $display("wrong value %s expected %h seen %h", nm, exp, got);
            err_total++;
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    // checks are made at the edge, before that edge's updates land
    task automatic set_mode(input logic [1:0] code);
        mode_cmd_valid <= 1'b1;
        mode_cmd <= code;
        tick(1);
        mode_cmd_valid <= 1'b0;
        tick(1);
        chk("test_mode", 16'h1 << code, test_mode);
        u_host.rx2.delete();
    endtask

    task automatic chk_echo(input int off, input int m,
            input logic [7:0] b0);
        for (int i = 0; i < m; i++)
            chk("echo", {b0 + 8'(i), i == m - 1}, u_host.rx2[off + i]);
    endtask

    // ========
    // scenarios
    task automatic t_reset();
        chk("mode", 16'h1, test_mode);
        chk("out2 ready", 16'h0, ep2_out_ready);
        chk("out1 ready", 16'h1, ep1_out_ready);
        chk("leds", 16'h0, led_pipe);
        chk("link", 16'h0, link_status_led);
    endtask

    task automatic t_key();
        slow <= 1'b1;
        test_key <= 1'b1;
        tick(12);
        test_key <= 1'b0;
        tick(12);
        slow <= 1'b0;
        chk("key count", 16'h4, 16'(u_host.rx1.size()));
        for (int i = 0; i < 4; i++)
            chk("key beat", key_exp[i], u_host.rx1[i]);
    endtask

    // trailing bytes past the generic limit must not disturb the LEDs
    task automatic t_led();
        for (int c = 0; c < 4; c++) begin
            u_host.send_pkt(1'b0, 20, 8'(3 - c));
            chk("leds", 16'(3 - c), led_pipe);
        end
    endtask

    task automatic t_loop();
        int k;
        set_mode(2'h1);
        slow <= 1'b1;
        u_host.send_pkt(1'b1, 3, 8'hA0);
        u_host.send_pkt(1'b1, 64, 8'h10);
        u_host.send_pkt(1'b1, 70, 8'h80);
        k = 0;
        while (u_host.rx2.size() < 131 && k < 600) begin
            tick(1);
            k++;
        end
        tick(4);
        slow <= 1'b0;
        chk("echo count", 16'h83, 16'(u_host.rx2.size()));
        chk_echo(0, 3, 8'hA0);
        chk_echo(3, 64, 8'h10);
        chk_echo(67, 64, 8'h80);
    endtask

    task automatic t_print();
        time t0;
        set_mode(2'h2);
        chk("out2 ready", 16'h1, ep2_out_ready);
        t0 = $time;
        u_host.send_pkt(1'b1, 64, 8'h00);
        chk("print cycles", 16'h41, 16'(($time - t0) / 10));
        tick(4);
        chk("print echo", 16'h0, 16'(u_host.rx2.size()));
    endtask

    task automatic t_scan();
        set_mode(2'h3);
        chk("out2 ready", 16'h0, ep2_out_ready);
        saw = 2'h0;
        for (int i = 0; i < 140; i++) begin
            tick(1);
            saw[link_status_led] = 1'b1;
        end
        chk("blink", 16'h3, saw);
        for (int i = 0; i < 128; i++)
            chk("scan", {8'(i % 64), i % 64 == 63}, u_host.rx2[i]);
    endtask

    task automatic t_link();
        set_mode(2'h0);
        chk("out2 ready", 16'h0, ep2_out_ready);
        tick(4 * BH);
        saw = 2'h0;
        for (int i = 0; i < 20; i++) begin
            tick(1);
            saw[link_status_led] = 1'b1;
        end
        chk("link steady", 16'h2, saw);
        configured <= 1'b0;
        tick(2);
        chk("link off", 16'h0, link_status_led);
    endtask

    task automatic t_susp();
        bus_suspended <= 1'b1;
        tick(2);
        chk("suspend", 16'h1, suspend_indicator);
        bus_suspended <= 1'b0;
        tick(1);
        chk("suspend", 16'h1, suspend_indicator);
        tick(1);
        chk("suspend", 16'h0, suspend_indicator);
        tick(2);
        chk("wake pulses", 16'h1, 16'(wake_count));
    endtask

    // ========
    // hang guard and main sequence
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 5000) begin
            err_total++;
            complete_run();
        end
    end

    initial begin
        tick(4);
        rst <= 1'b0;
        t_reset();
        configured <= 1'b1;
        t_key();
        t_led();
        t_loop();
        t_print();
        t_scan();
        t_link();
        t_susp();
        complete_run();
    end
endmodule
